// ==== ddrb_sram_core.sv ====
// Function
// - Second burst address flips first address LSB
// - Powers up deselected, data outputs released
// - Write words at t+1 rise pairs
// - Write data captured on both input edges
// - Read data on output clocks, else inputs
// - 18-bit: lanes gate bits 8:0, 17:9
// - Lane selects sampled with every data word
// - All lanes high writes nothing
`timescale 1ns/1ps

module ddrb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] DEPTH_CNT = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] LAST_SLOT = PW'(DEPTH - 1);

  logic [WIDTH-1:0] store [0:DEPTH-1];
  logic [PW-1:0] wr_ptr, next_wr_ptr;
  logic [PW-1:0] rd_ptr, next_rd_ptr;
  logic [PW:0] count, next_count;
  logic push, pop;

  assign o_in_ready = (count != DEPTH_CNT);
  assign o_out_valid = (count != '0);
  assign o_out_data = store[rd_ptr];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  // Pointer and fill bookkeeping; wrap handles non power of two depths
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push) begin
      next_wr_ptr = (wr_ptr == LAST_SLOT) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == LAST_SLOT) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // Storage needs no reset; count guards stale slots
  always_ff @(posedge i_clk) begin
    if (push) begin
      store[wr_ptr] <= i_in_data;
    end
  end
endmodule

module ddrb_sram_core import ddrb_pkg::*; #(
  parameter int ARRAY_AW = DDRB_ADDR_W,
  parameter int FIFO_DEPTH = DDRB_FIFO_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_k,
  input wire logic i_k_n,
  input wire logic i_c,
  input wire logic i_c_n,
  input wire logic i_transfer_request_n,
  input wire logic i_read_not_write,
  input wire logic [DDRB_ADDR_W-1:0] i_addr,
  input wire logic [DDRB_DATA_W-1:0] i_data,
  input wire logic [DDRB_LANES-1:0] i_byte_lane_select_n,
  output logic [DDRB_DATA_W-1:0] o_q,
  output logic o_q_oe_n,
  output logic o_single_clock,
  output logic o_write_dropped
);
  // Pin clock edge detection; pins are synchronous, so no synchroniser
  logic k_q, k_n_q, c_q, c_n_q;
  logic k_rise, k_n_rise, out_a, out_b;

  // Strap capture
  logic strap_done, next_strap_done, next_single_clock;

  // Write pipeline: pending holds cycle t, active holds the K# word of t+1
  logic wr_pend_v, next_wr_pend_v, wr_act_v, next_wr_act_v;
  logic [DDRB_ADDR_W-1:0] wr_pend_addr, next_wr_pend_addr;
  logic [DDRB_ADDR_W-1:0] wr_act_addr, next_wr_act_addr;
  ddrb_wr_word_s push_word, drain_word;
  logic push_try, push_valid, push_ready, drain_valid, drain_ready;
  logic next_write_dropped;

  // Read pipeline
  ddrb_rd_state_e rd_state, next_rd_state;
  logic rd_pend_v, next_rd_pend_v;
  logic [DDRB_ADDR_W-1:0] rd_pend_addr, next_rd_pend_addr;
  logic [DDRB_ADDR_W-1:0] rd_act_addr, next_rd_act_addr;
  logic [DDRB_DATA_W-1:0] next_q;
  logic next_q_oe_n, rd_launch;
  logic [DDRB_ADDR_W-1:0] rd_word_addr;

  logic [DDRB_DATA_W-1:0] mem [0:(2**ARRAY_AW)-1];
  logic start_write, start_read;

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      k_q <= 1'b1;
      k_n_q <= 1'b1;
      c_q <= 1'b1;
      c_n_q <= 1'b1;
    end else begin
      k_q <= i_k;
      k_n_q <= i_k_n;
      c_q <= i_c;
      c_n_q <= i_c_n;
    end
  end

  // One-cycle enables, one per rising clock edge seen on the pins
  assign k_rise = i_k && !k_q;
  assign k_n_rise = i_k_n && !k_n_q;
  // Word one on the negative output edge, word two on the positive one;
  // single mode maps these to K# then K, as if C had zero skew to K
  assign out_a = o_single_clock ? k_n_rise : (i_c_n && !c_n_q);
  assign out_b = o_single_clock ? k_rise : (i_c && !c_q);

  // Transactions open at a K rise with the request low
  assign start_write = k_rise && !i_transfer_request_n &&
    (i_read_not_write != DDRB_RNW_READ);
  assign start_read = k_rise && !i_transfer_request_n &&
    (i_read_not_write == DDRB_RNW_READ);

  // Strap is caught once after each reset release, then frozen until the next reset
  always_comb begin
    next_strap_done = 1'b1;
    next_single_clock = o_single_clock;
    if (!strap_done) begin
      next_single_clock = ({i_c, i_c_n} == DDRB_SINGLE_STRAP);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      strap_done <= 1'b0;
      o_single_clock <= 1'b0;
    end else begin
      strap_done <= next_strap_done;
      o_single_clock <= next_single_clock;
    end
  end

  // Write capture: word one at K(t+1), word two at K#(t+1)
  always_comb begin
    next_wr_pend_v = wr_pend_v;
    next_wr_pend_addr = wr_pend_addr;
    next_wr_act_v = wr_act_v;
    next_wr_act_addr = wr_act_addr;
    push_try = 1'b0;
    push_word = DDRB_WORD_RESET;
    if (k_rise) begin
      next_wr_pend_v = start_write;
      next_wr_pend_addr = i_addr;
      next_wr_act_v = wr_pend_v;
      next_wr_act_addr = wr_pend_addr;
      push_try = wr_pend_v;
      push_word.addr = wr_pend_addr;
    end else if (k_n_rise && wr_act_v) begin
      next_wr_act_v = 1'b0;
      push_try = 1'b1;
      push_word.addr = wr_act_addr ^ DDRB_BURST_FLIP;
    end
    push_word.data = i_data;
    push_word.lane_n = i_byte_lane_select_n;
  end

  // Fully masked words never enter the buffer
  assign push_valid = push_try && (push_word.lane_n != DDRB_LANES_OFF);
  // Overflow is sticky; pins cannot be stalled, so the loss is reported
  assign next_write_dropped = o_write_dropped || (push_valid && !push_ready);

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      wr_pend_v <= 1'b0;
      wr_pend_addr <= DDRB_ADDR_RESET;
      wr_act_v <= 1'b0;
      wr_act_addr <= DDRB_ADDR_RESET;
      o_write_dropped <= 1'b0;
    end else begin
      wr_pend_v <= next_wr_pend_v;
      wr_pend_addr <= next_wr_pend_addr;
      wr_act_v <= next_wr_act_v;
      wr_act_addr <= next_wr_act_addr;
      o_write_dropped <= next_write_dropped;
    end
  end

  ddrb_fifo #(
    .WIDTH($bits(ddrb_wr_word_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_in_valid(push_valid),
    .o_in_ready(push_ready),
    .i_in_data(push_word),
    .o_out_valid(drain_valid),
    .i_out_ready(drain_ready),
    .o_out_data(drain_word)
  );

  // Array port is shared; a read launch stalls the drain for that cycle
  assign drain_ready = !rd_launch;

  // Lane-gated array write; deselected lanes keep old contents
  always_ff @(posedge i_clk) begin
    if (drain_valid && drain_ready) begin
      for (int l = 0; l < DDRB_LANES; l++) begin
        if (!drain_word.lane_n[l]) begin
          mem[drain_word.addr[ARRAY_AW-1:0]][l*DDRB_LANE_W +: DDRB_LANE_W] <=
            drain_word.data[l*DDRB_LANE_W +: DDRB_LANE_W];
        end
      end
    end
  end

  // Read burst: activate at K(t+1), word one on out_a, word two on out_b
  always_comb begin
    next_rd_state = rd_state;
    next_rd_pend_v = rd_pend_v;
    next_rd_pend_addr = rd_pend_addr;
    next_rd_act_addr = rd_act_addr;
    next_q = o_q;
    next_q_oe_n = o_q_oe_n;
    rd_launch = 1'b0;
    rd_word_addr = rd_act_addr;
    case (rd_state)
      DDRB_RD_FIRST: begin
        if (out_a) begin
          rd_launch = 1'b1;
          next_q_oe_n = 1'b0;
          next_rd_state = DDRB_RD_SECOND;
        end
      end
      DDRB_RD_SECOND: begin
        if (out_b) begin
          rd_launch = 1'b1;
          rd_word_addr = rd_act_addr ^ DDRB_BURST_FLIP;
          next_rd_state = DDRB_RD_IDLE;
        end
      end
      DDRB_RD_IDLE: begin
        // Release the bus on the next word-one edge with no burst running
        if (out_a) begin
          next_q_oe_n = DDRB_OE_N_OFF;
        end
      end
      default: begin
        next_rd_state = DDRB_RD_IDLE;
      end
    endcase
    if (rd_launch) begin
      next_q = mem[rd_word_addr[ARRAY_AW-1:0]];
    end
    if (k_rise) begin
      next_rd_pend_v = start_read;
      next_rd_pend_addr = i_addr;
      if (rd_pend_v) begin
        next_rd_act_addr = rd_pend_addr;
        next_rd_state = DDRB_RD_FIRST;
      end
    end
  end

  // Outputs start deselected and released
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      rd_state <= DDRB_RD_IDLE;
      rd_pend_v <= 1'b0;
      rd_pend_addr <= DDRB_ADDR_RESET;
      rd_act_addr <= DDRB_ADDR_RESET;
      o_q <= DDRB_Q_RESET;
      o_q_oe_n <= DDRB_OE_N_OFF;
    end else begin
      rd_state <= next_rd_state;
      rd_pend_v <= next_rd_pend_v;
      rd_pend_addr <= next_rd_pend_addr;
      rd_act_addr <= next_rd_act_addr;
      o_q <= next_q;
      o_q_oe_n <= next_q_oe_n;
    end
  end
endmodule

// ==== ddrb_pkg.sv ====
package ddrb_pkg;

  // Array geometry
  localparam int DDRB_ADDR_W = 20;
  localparam int DDRB_DATA_W = 18;
  localparam int DDRB_LANE_W = 9;
  localparam int DDRB_LANES = DDRB_DATA_W / DDRB_LANE_W;
  localparam int DDRB_FIFO_DEPTH = 8;

  // Burst and pin encodings
  localparam logic [DDRB_ADDR_W-1:0] DDRB_BURST_FLIP = 20'h00001;
  localparam logic [DDRB_LANES-1:0] DDRB_LANES_OFF = {DDRB_LANES{1'b1}};
  localparam logic DDRB_RNW_READ = 1'b1;
  localparam logic [1:0] DDRB_SINGLE_STRAP = 2'b11;

  // Reset values
  localparam logic DDRB_OE_N_OFF = 1'b1;
  localparam logic [DDRB_DATA_W-1:0] DDRB_Q_RESET = 18'h00000;
  localparam logic [DDRB_ADDR_W-1:0] DDRB_ADDR_RESET = 20'h00000;

  // One masked write word on its way to the array
  typedef struct packed {
    logic [DDRB_ADDR_W-1:0] addr;
    logic [DDRB_DATA_W-1:0] data;
    logic [DDRB_LANES-1:0] lane_n;
  } ddrb_wr_word_s;

  localparam ddrb_wr_word_s DDRB_WORD_RESET = '0;

  // Read burst sequencer
  typedef enum logic [2:0] {
    DDRB_RD_IDLE = 3'b001,
    DDRB_RD_FIRST = 3'b010,
    DDRB_RD_SECOND = 3'b100
  } ddrb_rd_state_e;

endpackage

// ==== ddrb_sram_core_unused_note.sv ====
`timescale 1ns/1ps

// ==== ddrb_ctrl_model.sv ====
`timescale 1ns/1ps
module ddrb_ctrl_model import ddrb_pkg::*; (
  input wire logic i_clk,
  output logic o_k,
  output logic o_k_n,
  output logic o_req_n,
  output logic o_rnw,
  output logic [DDRB_ADDR_W-1:0] o_addr,
  output logic [DDRB_DATA_W-1:0] o_data,
  output logic [DDRB_LANES-1:0] o_lane_n,
  input wire logic [DDRB_DATA_W-1:0] i_q,
  input wire logic i_q_oe_n
);
  logic [DDRB_DATA_W:0] s1;
  logic [DDRB_DATA_W:0] s2;
  // Clocks parked high until the first frame
  initial begin
    o_k = 1'b1;
    o_k_n = 1'b1;
    o_req_n = 1'b1;
    o_rnw = 1'b0;
    o_addr = '0;
    o_data = '0;
    o_lane_n = DDRB_LANES_OFF;
  end
  // Stop with both clocks high for a quick restart
  task automatic park();
    @(posedge i_clk);
    o_k <= 1'b1;
    o_k_n <= 1'b1;
  endtask
  // K must be low once so the first period gives a rise
  task automatic wake();
    @(posedge i_clk);
    o_k <= 1'b0;
  endtask
  // One K period of four cycles; request at K rise
  task automatic per(input logic rq, rw, input logic [DDRB_ADDR_W-1:0] a,
      input logic [DDRB_DATA_W-1:0] d0, d1, input logic [DDRB_LANES-1:0] l0, l1);
    @(posedge i_clk);
    o_k <= 1'b1;
    o_k_n <= 1'b0;
    o_req_n <= rq;
    o_rnw <= rw;
    o_addr <= a;
    o_data <= d0;
    o_lane_n <= l0;
    @(negedge i_clk);
    s1 = {i_q_oe_n, i_q};
    @(posedge i_clk);
    o_req_n <= 1'b1;
    o_addr <= ~a; // Address past its hold shows junk
    @(posedge i_clk);
    o_k <= 1'b0;
    o_k_n <= 1'b1;
    o_data <= d1;
    o_lane_n <= l1;
    @(posedge i_clk);
    o_data <= ~d1;
    @(negedge i_clk);
    s2 = {i_q_oe_n, i_q};
  endtask
endmodule

// ==== ddrb_sram_core_checker.sv ====
`timescale 1ns/1ps
module ddrb_sram_core_checker import ddrb_pkg::*; #(
  parameter int ARRAY_AW = DDRB_ADDR_W,
  parameter int FIFO_DEPTH = DDRB_FIFO_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_k,
  input wire logic i_c,
  input wire logic i_c_n,
  input wire logic i_transfer_request_n,
  input wire logic i_read_not_write,
  input wire logic [DDRB_DATA_W-1:0] o_q,
  input wire logic o_q_oe_n,
  input wire logic o_single_clock,
  input wire logic o_write_dropped
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  logic k_prev, next_k_prev, start;
  logic [4:0] rd_age, next_rd_age, wr_age, next_wr_age;
  // Saturating ages since the last request, so they never wrap
  always_comb begin
    start = i_k && !k_prev && !i_transfer_request_n;
    next_k_prev = i_k;
    next_rd_age = (rd_age == 5'h1f) ? rd_age : rd_age + 5'h01;
    next_wr_age = (wr_age == 5'h1f) ? wr_age : wr_age + 5'h01;
    if (start && i_read_not_write) next_rd_age = 5'h00;
    if (start && !i_read_not_write) next_wr_age = 5'h00;
    if (!i_rstn) begin
      next_k_prev = 1'b1;
      next_rd_age = 5'h1f;
      next_wr_age = 5'h1f;
    end
  end
  always_ff @(posedge i_clk) begin
    k_prev <= next_k_prev;
    rd_age <= next_rd_age;
    wr_age <= next_wr_age;
  end
  a_reset_quiet: assert property (disable iff (1'b0) !i_rstn |=> o_q_oe_n &&
    o_q == DDRB_Q_RESET && !o_write_dropped && !o_single_clock) else $error("reset values");
  a_strap_take: assert property (i_rstn && !$past(i_rstn) |=>
    o_single_clock == ($past(i_c) && $past(i_c_n))) else $error("strap not taken");
  a_strap_fixed: assert property ($past(i_rstn) && $past(i_rstn, 2) |->
    $stable(o_single_clock)) else $error("strap changed");
  a_oe_release: assert property (rd_age == 5'h1f |-> o_q_oe_n)
    else $error("outputs driven without read");
  a_oe_cause: assert property ($fell(o_q_oe_n) |-> rd_age < 5'd14)
    else $error("drive began without read");
  a_q_moves: assert property ($changed(o_q) |-> !o_q_oe_n && rd_age < 5'd14)
    else $error("read data moved outside a read");
  a_drop_sticky: assert property (o_write_dropped |=> o_write_dropped)
    else $error("drop flag cleared");
  a_drop_cause: assert property ($rose(o_write_dropped) |-> wr_age < 5'd20)
    else $error("drop without write");
endmodule
bind ddrb_sram_core ddrb_sram_core_checker #(.ARRAY_AW(ARRAY_AW), .FIFO_DEPTH(FIFO_DEPTH)) chk (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_k(i_k), .i_c(i_c), .i_c_n(i_c_n),
  .i_transfer_request_n(i_transfer_request_n), .i_read_not_write(i_read_not_write),
  .o_q(o_q), .o_q_oe_n(o_q_oe_n), .o_single_clock(o_single_clock),
  .o_write_dropped(o_write_dropped));

// ==== ddrb_sram_core_bench.sv ====
`timescale 1ns/1ps
module ddrb_sram_core_bench import ddrb_pkg::*;;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic k, k_n, req_n, rnw, oe_n, single, dropped;
  logic [DDRB_ADDR_W-1:0] addr;
  logic [DDRB_DATA_W-1:0] data, q;
  logic [DDRB_LANES-1:0] lane_n;
  logic [DDRB_DATA_W-1:0] mem [0:255];
  int err_total = 0;
  int check_count = 0;
  int cyc = 0;
  logic normal = 1'b0;
  logic c_on = 1'b0;
  logic c, c_n;
  always #2.5 clk = ~clk;
  // Both output clocks high select single mode; else C is held low until c_on is set, then mirrors K
  assign c = normal ? (k && c_on) : 1'b1;
  assign c_n = normal ? (k_n && c_on) : 1'b1;
  ddrb_sram_core #(.ARRAY_AW(8)) uut (.i_clk(clk), .i_rstn(rstn), .i_k(k), .i_k_n(k_n),
    .i_c(c), .i_c_n(c_n), .i_transfer_request_n(req_n), .i_read_not_write(rnw),
    .i_addr(addr), .i_data(data), .i_byte_lane_select_n(lane_n), .o_q(q),
    .o_q_oe_n(oe_n), .o_single_clock(single), .o_write_dropped(dropped));
  ddrb_ctrl_model ctl (.i_clk(clk), .o_k(k), .o_k_n(k_n), .o_req_n(req_n), .o_rnw(rnw),
    .o_addr(addr), .o_data(data), .o_lane_n(lane_n), .i_q(q), .i_q_oe_n(oe_n));
  task automatic chk(input string what, input logic [18:0] exp, got);
    check_count++;
    if (exp !== got) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Reference array, one lane at a time
  task automatic put(input logic [7:0] a, input logic [17:0] d, input logic [1:0] l);
    for (int i = 0; i < DDRB_LANES; i++) if (!l[i]) mem[a][i*9 +: 9] = d[i*9 +: 9];
  endtask
  task automatic wr(input logic [7:0] a, input logic [17:0] d0, d1, input logic [1:0] l0, l1);
    ctl.wake();
    ctl.per(1'b0, 1'b0, 20'(a), ~d0, ~d1, 2'h0, 2'h0);
    ctl.per(1'b1, 1'b0, 20'(~a), d0, d1, l0, l1);
    ctl.park();
    put(a, d0, l0);
    put(a ^ 8'h01, d1, l1);
    repeat (12) @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    ctl.wake();
    ctl.per(1'b0, 1'b1, 20'(a), 18'h0, 18'h0, 2'h3, 2'h3);
    repeat (2) ctl.per(1'b1, 1'b0, 20'(~a), 18'h0, 18'h0, 2'h3, 2'h3);
    chk("word1", {1'b0, mem[a]}, ctl.s1);
    chk("word2", {1'b0, mem[a ^ 8'h01]}, {1'b0, ctl.s2[17:0]});
    ctl.per(1'b1, 1'b0, 20'(a), 18'h0, 18'h0, 2'h3, 2'h3);
    chk("release", 19'h40000, {ctl.s1[18], 18'h0});
    ctl.park();
  endtask
  task automatic t_reset();
    chk("idle", {DDRB_OE_N_OFF, DDRB_Q_RESET}, {oe_n, q});
    chk("strap", 19'h1, {18'h0, single});
    chk("drop", 19'h0, {18'h0, dropped});
    $display("test reset done");
  endtask
  task automatic t_burst();
    wr(8'h10, 18'h12345, 18'h0abcd, 2'h0, 2'h0);
    wr(8'h21, 18'h2aaaa, 18'h15555, 2'h0, 2'h0);
    rd(8'h10);
    rd(8'h21);
    rd(8'h20);
    $display("test burst done");
  endtask
  task automatic t_lanes();
    for (int m = 0; m < 4; m++) begin
      wr(8'h40, 18'h3ffff, 18'h00000, 2'h0, 2'h0);
      wr(8'h40, 18'h0f0f0, 18'h30303, 2'(m), 2'(~m));
      rd(8'h40);
    end
    $display("test lanes done");
  endtask
  // Back-to-back writes, then data behind a non-request must not land
  task automatic t_b2b();
    wr(8'h70, 18'h01234, 18'h04321, 2'h0, 2'h0);
    ctl.wake();
    ctl.per(1'b0, 1'b0, 20'h00050, 18'h0, 18'h0, 2'h0, 2'h0);
    ctl.per(1'b0, 1'b0, 20'h00063, 18'h11111, 18'h22222, 2'h0, 2'h0);
    ctl.per(1'b1, 1'b0, 20'h00070, 18'h33333, 18'h04444, 2'h0, 2'h0);
    ctl.per(1'b1, 1'b0, 20'h00070, 18'h05555, 18'h06666, 2'h0, 2'h0);
    ctl.park();
    put(8'h50, 18'h11111, 2'h0);
    put(8'h51, 18'h22222, 2'h0);
    put(8'h63, 18'h33333, 2'h0);
    put(8'h62, 18'h04444, 2'h0);
    repeat (12) @(posedge clk);
    rd(8'h50);
    rd(8'h62);
    rd(8'h70);
    chk("no drop", 19'h0, {18'h0, dropped});
    $display("test back to back done");
  endtask
  // Mid-run reset with output clocks low picks normal mode; C then mirrors K
  task automatic t_normal();
    rstn <= 1'b0;
    normal <= 1'b1;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("normal idle", {DDRB_OE_N_OFF, DDRB_Q_RESET}, {oe_n, q});
    chk("normal strap", 19'h0, {18'h0, single});
    @(posedge clk);
    c_on <= 1'b1;
    wr(8'h90, 18'h2468a, 18'h13579, 2'h0, 2'h1);
    rd(8'h90);
    rd(8'h10);
    $display("test normal mode done");
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Hang guard; the full run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      wrap_up();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    t_reset();
    t_burst();
    t_lanes();
    t_b2b();
    t_normal();
    wrap_up();
  end
endmodule
